// file: common/eeprom_map.svh
// Constants of the three-wire serial EEPROM: frame widths, opcodes, timing.
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// Frame field widths for the two word organisations.
`define ADDR_BITS_X16      8
`define ADDR_BITS_X8       9
`define DATA_BITS_X16      16
`define DATA_BITS_X8       8
`define OPCODE_BITS        2

// Storage size in bytes and stream buffer shape.
`define MEM_BYTES          256
`define FIFO_DEPTH         32
`define FIFO_WIDTH         16

// Opcodes and the subcodes carried in the top address bits.
`define OPC_EXTENDED       2'h0
`define OPC_WRITE          2'h1
`define OPC_READ           2'h2
`define OPC_ERASE          2'h3
`define SUB_DISABLE        2'h0
`define SUB_FILL_ALL       2'h1
`define SUB_CLEAR_ALL      2'h2
`define SUB_ENABLE         2'h3

// Value of an erased byte and reset values.
`define ERASED_BYTE        8'hff
`define WEL_RESET          1'h0

// Timing: reference clock rate and the derived cycle counts.
`define REF_CLK_KHZ        40000
`define PROG_TIME_US       5000
`define PROG_CYCLES        ((`PROG_TIME_US * `REF_CLK_KHZ) / 1000)
`define MIN_SEL_LOW_NS     250
`define MIN_SEL_LOW_CYCLES ((`MIN_SEL_LOW_NS * `REF_CLK_KHZ + 999999) / 1000000)
`define POWERUP_READ_US    1000

`endif

// file: common/eeprom_pkg.sv
// Types shared by the serial EEPROM command logic.
package eeprom_pkg;
`include "eeprom_map.svh"

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPCODE,
      ST_ADDR,
      ST_DATA,
      ST_READ,
      ST_SKIP
   } frame_state_e;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_WRITE,
      OP_ERASE,
      OP_CLEAR_ALL,
      OP_FILL_ALL
   } prog_op_e;

   typedef struct packed {
      prog_op_e    op;
      logic        x16;
      logic [8:0]  addr;
      logic [15:0] data;
   } prog_cmd_s;
endpackage

// file: design/serial_eeprom.sv
// Serial EEPROM command logic with read stream buffer and program timer.
//
// Summary of operation
// - word width select high means 16-bit words.
// - data in sampled on rising serial clock.
// - start bit, opcode, address, then optional data.
// - instruction is eleven or twelve bits long.
// - opcodes 10 read, 11 erase, 01 write.
// - subcodes 11 enable, 00 disable programming.
// - subcode 10 clears all, 01 fills all.
// - data out floats except read or status.
// - select high reports busy low, ready high.
// - dummy one on data in ends status.
// - read emits dummy zero then word MSB-first.
// - read output bits change on rising clock.
// - sequential read advances address and wraps.
// - only first read word has dummy zero.
// - programming latch cleared after power-up.
// - latch holds until disable; gates programming.
// - reads work regardless of the latch.
// - falling select starts the single write cycle.
// - self-timed cycle needs no clock, bounded time.
// - single write clears before storing.
// - erase sets addressed location to all ones.
// - clear-all sets every location to ones.
// - fill-all stores data word everywhere.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Stream buffer between the array fetch and the output shifter.
module stream_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             en_i,
   input  wire logic             flush_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] store_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   wire              push;
   wire              pop;

   // Handshake terms; full and empty come straight from the count.
   assign in_ready_o  = (count_r != FULL_CNT);
   assign out_valid_o = (count_r != '0);
   assign out_data_o  = store_r[rd_ptr_r];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Pointers and occupancy; a flush empties the buffer in one cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else if (en_i) begin
         if (flush_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
         end else begin
            if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
         end
      end
   end

   // Data storage needs no reset; nothing reads an unwritten slot.
   always_ff @(posedge clk_i) begin
      if (en_i && !flush_i && push) begin
         store_r[wr_ptr_r] <= in_data_i;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////
// Device side of the three-wire serial EEPROM.
module serial_eeprom #(
   parameter int PROG_CYCLES = `PROG_CYCLES
) (
   input  wire logic ref_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic clk_en_i,
   input  wire logic select_i,
   input  wire logic serial_clock_i,
   input  wire logic serial_data_in_i,
   input  wire logic word_width_select_i,
   output logic      serial_data_out_o,
   output logic      serial_data_out_oe_n_o
);
   import eeprom_pkg::*;

   localparam int TW = $clog2(PROG_CYCLES + 1);

   logic [1:0]      sel_q;
   logic [1:0]      sk_q;
   logic [1:0]      di_q;
   logic [1:0]      org_q;
   logic            sel_prev_r;
   logic            sk_prev_r;
   frame_state_e    state_r;
   logic [4:0]      cnt_r;
   logic            x16_r;
   logic [1:0]      opc_r;
   logic [8:0]      addr_r;
   logic [15:0]     data_r;
   logic            wel_r;
   prog_cmd_s       pend_r;
   prog_cmd_s       prog_r;
   logic            busy_r;
   logic [TW-1:0]   timer_r;
   logic [7:0]      prog_idx_r;
   logic [8:0]      prog_left_r;
   logic            armed_r;
   logic            status_r;
   logic            fetch_on_r;
   logic [7:0]      fetch_addr_r;
   logic [15:0]     out_word_r;
   logic [4:0]      out_left_r;
   logic            dout_r;
   logic            oe_n_r;
   logic [7:0]      mem_r [`MEM_BYTES];

   wire             sel;
   wire             di;
   wire             sel_rise;
   wire             sel_fall;
   wire             bit_in;
   wire [8:0]       addr_nxt;
   wire [15:0]      data_nxt;
   wire [4:0]       addr_last_idx;
   wire [4:0]       data_last_idx;
   wire             start_bit;
   wire             opc_last;
   wire             addr_last;
   wire             data_last;
   wire [1:0]       subcode;
   wire             is_read;
   wire             is_ext;
   wire             read_bit;
   wire             prog_go;
   wire             prog_erase;
   wire [7:0]       prog_byte;
   wire             fifo_in_ready;
   wire [15:0]      fetch_word;
   wire [7:0]       fetch_inc;
   wire             fifo_out_valid;
   wire [15:0]      fifo_head;
   wire             fifo_pop;
   wire             fifo_flush;
   wire [15:0]      shift_src;
   wire             shift_bit;
   prog_op_e        addr_op;
   prog_cmd_s       pend_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; only the second stage is looked at.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         sel_q      <= '0;
         sk_q       <= '0;
         di_q       <= '0;
         org_q      <= 2'h3;
         sel_prev_r <= 1'b0;
         sk_prev_r  <= 1'b0;
      end else if (clk_en_i) begin
         sel_q      <= {sel_q[0], select_i};
         sk_q       <= {sk_q[0], serial_clock_i};
         di_q       <= {di_q[0], serial_data_in_i};
         org_q      <= {org_q[0], word_width_select_i};
         sel_prev_r <= sel_q[1];
         sk_prev_r  <= sk_q[1];
      end
   end

   // Edge and frame-position decode.
   assign sel      = sel_q[1];
   assign di       = di_q[1];
   assign sel_rise = sel & ~sel_prev_r;
   assign sel_fall = ~sel & sel_prev_r;
   assign bit_in   = sel & sk_q[1] & ~sk_prev_r;
   assign addr_nxt = {addr_r[7:0], di};
   assign data_nxt = {data_r[14:0], di};
   assign addr_last_idx = x16_r ? 5'(`ADDR_BITS_X16 - 1)
                                : 5'(`ADDR_BITS_X8 - 1);
   assign data_last_idx = x16_r ? 5'(`DATA_BITS_X16 - 1)
                                : 5'(`DATA_BITS_X8 - 1);
   assign start_bit = bit_in && state_r == ST_IDLE && di;
   assign opc_last  = bit_in && state_r == ST_OPCODE &&
                      cnt_r == 5'(`OPCODE_BITS - 1);
   assign addr_last = bit_in && state_r == ST_ADDR && cnt_r == addr_last_idx;
   assign data_last = bit_in && state_r == ST_DATA && cnt_r == data_last_idx;
   assign subcode   = x16_r ? addr_nxt[7:6] : addr_nxt[8:7];
   assign is_read   = (opc_r == `OPC_READ);
   assign is_ext    = (opc_r == `OPC_EXTENDED);
   assign read_bit  = bit_in && state_r == ST_READ;

   // Command that an address completes; data-bearing ones wait for data.
   always_comb begin
      addr_op = OP_NONE;
      case (opc_r)
         `OPC_ERASE:    addr_op = OP_ERASE;
         `OPC_EXTENDED: addr_op = (subcode == `SUB_CLEAR_ALL) ?
                                  OP_CLEAR_ALL : OP_NONE;
         default:       addr_op = OP_NONE;
      endcase
   end

   // Next pending command as the frame ends.
   always_comb begin
      pend_nxt = pend_r;
      if (start_bit) begin
         pend_nxt.op = OP_NONE;
      end else if (addr_last) begin
         pend_nxt.op   = addr_op;
         pend_nxt.x16  = x16_r;
         pend_nxt.addr = addr_nxt;
      end else if (data_last) begin
         pend_nxt.op   = is_ext ? OP_FILL_ALL : OP_WRITE;
         pend_nxt.data = data_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame state machine; deselect always returns it to idle.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state_r <= ST_IDLE;
         cnt_r   <= '0;
         x16_r   <= 1'b1;
      end else if (clk_en_i) begin
         if (!sel) begin
            state_r <= ST_IDLE;
         end else if (bit_in) begin
            cnt_r <= cnt_r + 5'h1;
            case (state_r)
               ST_IDLE: begin
                  cnt_r <= '0;
                  if (di) begin
                     state_r <= ST_OPCODE;
                     x16_r   <= org_q[1];
                  end
               end
               ST_OPCODE: begin
                  if (opc_last) begin
                     state_r <= ST_ADDR;
                     cnt_r   <= '0;
                  end
               end
               ST_ADDR: begin
                  if (addr_last) begin
                     cnt_r <= '0;
                     if (is_read) state_r <= ST_READ;
                     else if (opc_r == `OPC_WRITE ||
                              (is_ext && subcode == `SUB_FILL_ALL))
                        state_r <= ST_DATA;
                     else state_r <= ST_SKIP;
                  end
               end
               ST_DATA: if (data_last) state_r <= ST_SKIP;
               ST_READ: state_r <= ST_READ;
               ST_SKIP: state_r <= ST_SKIP;
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end

   // Shift registers for opcode, address and data fields.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         opc_r  <= '0;
         addr_r <= '0;
         data_r <= '0;
      end else if (clk_en_i && bit_in) begin
         if (state_r == ST_OPCODE) opc_r <= {opc_r[0], di};
         if (state_r == ST_ADDR) addr_r <= addr_nxt;
         if (state_r == ST_DATA) data_r <= data_nxt;
      end
   end

   // Programming latch; cleared by reset, only the two subcodes move it.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         wel_r <= `WEL_RESET;
      end else if (clk_en_i && addr_last && is_ext) begin
         if (subcode == `SUB_ENABLE) wel_r <= 1'b1;
         if (subcode == `SUB_DISABLE) wel_r <= 1'b0;
      end
   end

   // Pending command held until the select falls.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pend_r <= '0;
      end else if (clk_en_i) begin
         pend_r <= pend_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Self-timed cycle: falling select starts it, only if the latch is set.
   assign prog_go    = sel_fall && pend_r.op != OP_NONE &&
                       wel_r && !busy_r;
   assign prog_erase = (prog_r.op == OP_ERASE) ||
                       (prog_r.op == OP_CLEAR_ALL);
   // A write overwrites the whole location, which is the auto-clear.
   assign prog_byte  = prog_erase ? `ERASED_BYTE :
                       (prog_r.x16 && prog_idx_r[0]) ? prog_r.data[15:8] :
                       prog_r.data[7:0];

   // Timer and byte walker run on the reference clock, not the link.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         busy_r      <= 1'b0;
         timer_r     <= '0;
         prog_r      <= '0;
         prog_idx_r  <= '0;
         prog_left_r <= '0;
      end else if (clk_en_i) begin
         if (prog_go) begin
            busy_r  <= 1'b1;
            timer_r <= TW'(PROG_CYCLES - 1);
            prog_r  <= pend_r;
            if (pend_r.op == OP_CLEAR_ALL || pend_r.op == OP_FILL_ALL) begin
               prog_idx_r  <= '0;
               prog_left_r <= 9'(`MEM_BYTES);
            end else if (pend_r.x16) begin
               prog_idx_r  <= {pend_r.addr[6:0], 1'b0};
               prog_left_r <= 9'h2;
            end else begin
               prog_idx_r  <= pend_r.addr[7:0];
               prog_left_r <= 9'h1;
            end
         end else begin
            if (busy_r) begin
               timer_r <= timer_r - 1'b1;
               if (timer_r == '0) busy_r <= 1'b0;
            end
            if (prog_left_r != '0) begin
               prog_idx_r  <= prog_idx_r + 8'h1;
               prog_left_r <= prog_left_r - 9'h1;
            end
         end
      end
   end

   // Array write port, one byte per reference cycle.
   always_ff @(posedge ref_clk_i) begin
      if (clk_en_i && !prog_go && prog_left_r != '0) begin
         mem_r[prog_idx_r] <= prog_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read fetch fills the buffer ahead of the shifter; the latch is unused.
   assign fetch_word = x16_r ?
                       {mem_r[{fetch_addr_r[6:0], 1'b1}],
                        mem_r[{fetch_addr_r[6:0], 1'b0}]} :
                       {8'h00, mem_r[fetch_addr_r]};
   assign fetch_inc  = x16_r ? {1'b0, fetch_addr_r[6:0] + 7'h1} :
                       fetch_addr_r + 8'h1;
   assign fifo_flush = !sel || addr_last;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         fetch_on_r   <= 1'b0;
         fetch_addr_r <= '0;
      end else if (clk_en_i) begin
         if (!sel) begin
            fetch_on_r <= 1'b0;
         end else if (addr_last && is_read) begin
            fetch_on_r   <= 1'b1;
            fetch_addr_r <= x16_r ? {1'b0, addr_nxt[6:0]} : addr_nxt[7:0];
         end else if (fetch_on_r && fifo_in_ready) begin
            fetch_addr_r <= fetch_inc;       // Stalls while the buffer is full.
         end
      end
   end

   stream_fifo #(
      .WIDTH (`FIFO_WIDTH),
      .DEPTH (`FIFO_DEPTH)
   ) u_read_fifo (
      .clk_i       (ref_clk_i),
      .rst_i       (sys_rst_i),
      .en_i        (clk_en_i),
      .flush_i     (fifo_flush),
      .in_valid_i  (fetch_on_r),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (fetch_word),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_head)
   );

   // Output shifter: a new word is taken only when the last bit is gone.
   assign fifo_pop  = read_bit && out_left_r == '0 && fifo_out_valid;
   assign shift_src = (out_left_r == '0) ? fifo_head : out_word_r;
   assign shift_bit = x16_r ? shift_src[15] : shift_src[7];

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         out_word_r <= '0;
         out_left_r <= '0;
      end else if (clk_en_i) begin
         if (addr_last) begin
            out_left_r <= '0;
         end else if (read_bit) begin
            out_word_r <= shift_src << 1;
            // Words follow back to back with no further dummy bit.
            out_left_r <= (out_left_r == '0) ? data_last_idx :
                          out_left_r - 5'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status polling: armed by any programming command at deselect.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         armed_r  <= 1'b0;
         status_r <= 1'b0;
      end else if (clk_en_i) begin
         if (sel_fall && pend_r.op != OP_NONE) armed_r <= 1'b1;
         if (!sel) begin
            status_r <= 1'b0;
         end else if (start_bit) begin
            status_r <= 1'b0;
            armed_r  <= 1'b0;
         end else if (sel_rise && armed_r) begin
            status_r <= 1'b1;
         end
      end
   end

   // Pin driver; the enable is low only for read data or status.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         dout_r <= 1'b0;
         oe_n_r <= 1'b1;
      end else if (clk_en_i) begin
         if (!sel || start_bit) begin
            oe_n_r <= 1'b1;
         end else if (addr_last && is_read) begin
            oe_n_r <= 1'b0;
            dout_r <= 1'b0;
         end else if (read_bit) begin
            dout_r <= shift_bit;
         end else if (status_r) begin
            oe_n_r <= 1'b0;
            dout_r <= ~busy_r;
         end
      end
   end

   assign serial_data_out_o      = dout_r;
   assign serial_data_out_oe_n_o = oe_n_r;
endmodule

// file: bench/eeprom_host.sv
// Host-side model that clocks command frames into the serial EEPROM.
`timescale 1ns/1ps
module eeprom_host (
   input  wire logic clk_i,
   input  wire logic line_i,
   output logic      select_o,
   output logic      sk_o,
   output logic      di_o
);
   // Pins idle low; the serial clock stands still between frames.
   initial begin
      select_o = 1'b0;
      sk_o = 1'b0;
      di_o = 1'b0;
   end
   // Wait n reference edges, then move pins just after the last one.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Clock n bits of v MSB first; the line is sampled late in each
   // high phase so the answer to that rise has settled.
   task automatic shift(input logic [63:0] v, input int n,
                        output logic [63:0] got);
      got = '0;
      select_o = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         di_o = v[i];
         tick(8);
         sk_o = 1'b1;
         tick(7);
         got = {got[62:0], line_i};
         tick(1);
         sk_o = 1'b0;
      end
      di_o = 1'b0;
   endtask
   // Deselect longer than the minimum low time to launch a command.
   task automatic drop();
      tick(2);
      select_o = 1'b0;
      tick(12);
   endtask
endmodule

// file: bench/eeprom_checker.sv
// Concurrent checks on the serial EEPROM pins.
`timescale 1ns/1ps
module eeprom_checker #(
   parameter int PROG_CYCLES = 300
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   input wire logic select_i,
   input wire logic serial_clock_i,
   input wire logic serial_data_in_i,
   input wire logic word_width_select_i,
   input wire logic serial_data_out_o,
   input wire logic serial_data_out_oe_n_o
);
   logic [3:0] sk_hi, sel_hi, sel_lo;
   // Saturating pin-level ages, so every answer delay can be bounded.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         {sk_hi, sel_hi, sel_lo} <= '0;
      end else begin
         sk_hi  <= !serial_clock_i ? 4'h0 : sk_hi + 4'(sk_hi != 4'hf);
         sel_hi <= !select_i ? 4'h0 : sel_hi + 4'(sel_hi != 4'hf);
         sel_lo <= select_i ? 4'h0 : sel_lo + 4'(sel_lo != 4'hf);
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////////////////////////////////////
   property p_hiz_idle;
      sel_lo > 4'h6 |-> serial_data_out_oe_n_o;
   endproperty
   a_hiz_idle: assert property (p_hiz_idle)
      else $error("output driven while deselected");
   property p_reset_idle;
      $fell(sys_rst_i) |-> serial_data_out_oe_n_o && !serial_data_out_o;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("output not idle after reset");
   property p_status_delay;
      $fell(serial_data_out_oe_n_o) && sk_hi == 4'h0
         |-> sel_hi inside {[3:6]};
   endproperty
   a_status_delay: assert property (p_status_delay)
      else $error("status not tied to select rise");
   property p_read_dummy;
      $fell(serial_data_out_oe_n_o) && sk_hi != 4'h0
         |-> !serial_data_out_o && sk_hi inside {[3:6]};
   endproperty
   a_read_dummy: assert property (p_read_dummy)
      else $error("read did not open with a zero");
   property p_bit_on_rise;
      $fell(serial_data_out_o) && !serial_data_out_oe_n_o
         && !$past(serial_data_out_oe_n_o) |-> sk_hi inside {[3:6]};
   endproperty
   a_bit_on_rise: assert property (p_bit_on_rise)
      else $error("output bit changed off a clock rise");
   property p_release;
      $rose(serial_data_out_oe_n_o)
         |-> sel_lo inside {[3:6]} || sk_hi inside {[3:6]};
   endproperty
   a_release: assert property (p_release)
      else $error("output released without cause");
   property p_ready_only;
      $changed(serial_data_out_o) && !serial_data_out_oe_n_o
         && !$past(serial_data_out_oe_n_o) && !(sk_hi inside {[3:6]})
         |-> serial_data_out_o && select_i;
   endproperty
   a_ready_only: assert property (p_ready_only)
      else $error("status changed other than to ready");
   property p_quiet_status;
      !serial_clock_i && sel_hi == 4'hf |=> $stable(serial_data_out_oe_n_o);
   endproperty
   a_quiet_status: assert property (p_quiet_status)
      else $error("enable moved without clock or select");
   c_read: cover property ($fell(serial_data_out_oe_n_o) && sk_hi != 4'h0);
   c_ready: cover property ($rose(serial_data_out_o) && sk_hi == 4'h0);
   c_release: cover property ($rose(serial_data_out_oe_n_o) && select_i);
endmodule
bind serial_eeprom eeprom_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
   .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
   .select_i(select_i), .serial_clock_i(serial_clock_i),
   .serial_data_in_i(serial_data_in_i),
   .word_width_select_i(word_width_select_i),
   .serial_data_out_o(serial_data_out_o),
   .serial_data_out_oe_n_o(serial_data_out_oe_n_o));

// file: bench/tb_serial_eeprom.sv
// Self-checking testbench of the serial EEPROM command logic.
`timescale 1ns/1ps
`include "eeprom_map.svh"
module tb_serial_eeprom;
   import eeprom_pkg::*;
   logic ref_clk_i, sys_rst_i, width_r, en_r, line_w;
   logic sel_w, sk_w, di_w, dout_w, oe_n_w;
   logic [63:0] got;
   logic [31:0] seed;
   logic [15:0] fill_v, data_v;
   int failures, n_checks;
   serial_eeprom #(.PROG_CYCLES(300)) dut_u (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(en_r),
      .select_i(sel_w), .serial_clock_i(sk_w), .serial_data_in_i(di_w),
      .word_width_select_i(width_r), .serial_data_out_o(dout_w),
      .serial_data_out_oe_n_o(oe_n_w));
   eeprom_host host_u (.clk_i(ref_clk_i), .line_i(line_w),
      .select_o(sel_w), .sk_o(sk_w), .di_o(di_w));
   // A released line shows the inverse of its last value, never a hold.
   assign line_w = oe_n_w ? ~dout_w : dout_w;
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // Frame head: start bit, opcode, address of the current width.
   function automatic logic [63:0] cmd(input logic [1:0] op,
                                       input logic [8:0] a);
      return width_r ? {53'h0, 1'b1, op, a[7:0]} : {52'h0, 1'b1, op, a};
   endfunction
   function automatic logic [8:0] sub(input logic [1:0] s);
      return width_r ? {1'b0, s, 6'h0} : {s, 7'h0};
   endfunction
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic send(input logic [1:0] op, input logic [8:0] a,
                       input logic [15:0] d, input int nd);
      host_u.shift((cmd(op, a) << nd) | {48'h0, d},
                   (width_r ? 11 : 12) + nd, got);
      host_u.drop();
   endtask
   // Two idle zeros lead the frame; they must not count as a start.
   task automatic read(input logic [8:0] a, input int nb);
      host_u.shift(cmd(`OPC_READ, a) << nb, (width_r ? 13 : 14) + nb, got);
      host_u.drop();
   endtask
   task automatic poll(input logic busy);
      int k;
      host_u.select_o = 1'b1;
      host_u.tick(6);
      check("drive", 32'(oe_n_w), 32'h0);
      check("status", 32'(line_w), 32'(!busy));
      // Freezing the clock enable must also stop the program timer.
      if (busy) begin
         en_r = 1'b0;
         host_u.tick(400);
         en_r = 1'b1;
         host_u.tick(100);
         check("frozen", 32'(line_w), 32'h0);
      end
      for (k = 0; k < 1000 && line_w !== 1'b1; k++) host_u.tick(1);
      check("ready", 32'(line_w), 32'h1);
      if (line_w !== 1'b1) close_out();
      host_u.shift(64'h1, 1, got);
      check("release", 32'(oe_n_w), 32'h1);
      host_u.drop();
   endtask
   // Main sequence: reset, power-up wait, then the command scenarios.
   initial begin
      failures = 0;
      n_checks = 0;
      seed = 32'd73;
      width_r = 1'b1;
      en_r = 1'b1;
      sys_rst_i = 1'b1;
      host_u.tick(3);
      sys_rst_i = 1'b0;
      host_u.tick(40000);
      seed = xs(seed);
      fill_v = seed[15:0];
      seed = xs(seed);
      data_v = seed[15:0];
      send(`OPC_EXTENDED, sub(`SUB_ENABLE), 16'h0, 0);
      send(`OPC_EXTENDED, sub(`SUB_FILL_ALL), fill_v, 16);
      poll(1'b1);
      send(`OPC_WRITE, 9'h07f, data_v, 16);
      poll(1'b1);
      read(9'h07f, 32);
      check("dummy", 32'(got[32]), 32'h0);
      check("seq", got[31:0], {data_v, fill_v});
      width_r = 1'b0;
      host_u.tick(10);
      read(9'h0ff, 16);
      check("x8wrap", 32'(got[16:0]),
            32'({data_v[15:8], fill_v[7:0]}));
      seed = xs(seed);
      send(`OPC_WRITE, 9'h003, {8'h0, seed[7:0]}, 8);
      poll(1'b1);
      width_r = 1'b1;
      host_u.tick(10);
      read(9'h001, 16);
      check("pair", 32'(got[15:0]), {16'h0, seed[7:0], fill_v[7:0]});
      send(`OPC_ERASE, 9'h001, 16'h0, 0);
      poll(1'b1);
      read(9'h000, 32);
      check("erase", got[31:0], {fill_v, 16'hffff});
      for (int i = 0; i < 3; i++) begin
         seed = xs(seed);
         send(`OPC_WRITE, {4'h1, seed[20:16]}, seed[15:0], 16);
         poll(1'b1);
         read({4'h1, seed[20:16]}, 16);
         check("rand", 32'(got[16:0]), 32'(seed[15:0]));
      end
      send(`OPC_EXTENDED, sub(`SUB_DISABLE), 16'h0, 0);
      send(`OPC_WRITE, 9'h000, ~fill_v, 16);
      poll(1'b0);
      send(`OPC_EXTENDED, sub(`SUB_CLEAR_ALL), 16'h0, 0);
      poll(1'b0);
      read(9'h000, 16);
      check("locked", 32'(got[16:0]), 32'(fill_v));
      send(`OPC_EXTENDED, sub(`SUB_ENABLE), 16'h0, 0);
      send(`OPC_EXTENDED, sub(`SUB_CLEAR_ALL), 16'h0, 0);
      poll(1'b1);
      read(9'h07f, 32);
      check("clrall", got[32:1], 32'h7fffffff);
      sys_rst_i = 1'b1;
      host_u.tick(3);
      sys_rst_i = 1'b0;
      host_u.tick(5);
      send(`OPC_WRITE, 9'h005, data_v, 16);
      poll(1'b0);
      read(9'h005, 16);
      check("powerup", 32'(got[16:0]), 32'h0ffff);
      close_out();
   end
endmodule
